/* File: design/sag_pkg.sv */
// Constants, register map and helpers shared by the segment and analog port block.
package sag_pkg;

    // Bus widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 6;

    // Register index; the byte address is four times this.
    typedef logic [IDX_W-1:0] sag_idx_t;

    // Register indices.
    localparam sag_idx_t IDX_A_LAT = 6'h05;
    localparam sag_idx_t IDX_M_LAT = 6'h06;
    localparam sag_idx_t IDX_B_LAT = 6'h07;
    localparam sag_idx_t IDX_M_DIR = 6'h0c;
    localparam sag_idx_t IDX_B_PIN = 6'h0d;
    localparam sag_idx_t IDX_A_PIN = 6'h0f;
    localparam sag_idx_t IDX_A_SEL = 6'h2a;
    localparam sag_idx_t IDX_B_SEL = 6'h2b;
    localparam sag_idx_t IDX_CONV  = 6'h30;

    // Reset values and field positions.
    localparam logic [7:0] RST_ONES = 8'hff;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic       RST_FLAG = 1'b1;
    localparam int         FLAG_BIT = 0;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // True when the index names a register of the block.
    function automatic logic sag_mapped(input sag_idx_t i);
        return i inside {IDX_A_LAT, IDX_M_LAT, IDX_B_LAT, IDX_M_DIR, IDX_B_PIN,
                         IDX_A_PIN, IDX_A_SEL, IDX_B_SEL, IDX_CONV};
    endfunction

    // True when the index names a register that software may write.
    function automatic logic sag_writable(input sag_idx_t i);
        return i inside {IDX_A_LAT, IDX_M_LAT, IDX_B_LAT, IDX_M_DIR,
                         IDX_A_SEL, IDX_B_SEL, IDX_CONV};
    endfunction

endpackage

/* File: design/sag_axil.sv */
// AXI4-Lite slave that turns bus transfers into byte register accesses.
module sag_axil
    import sag_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic                   reg_wr_en,
    output sag_idx_t               reg_wr_idx,
    output logic [7:0]             reg_wr_data,
    output sag_idx_t               reg_rd_idx,
    input  wire logic [7:0]        reg_rd_data
);

    logic       aw_free_q;  // Write address slot is empty.
    logic       w_free_q;   // Write data slot is empty.
    logic       ar_free_q;  // Read slot is empty.
    sag_idx_t   aw_idx_q;   // Held write index.
    logic [7:0] w_data_q;   // Held low write byte.
    logic       w_lane_q;   // Low byte lane was enabled.

    // Handshakes and the moment both halves of a write are held.
    wire aw_take  = awvalid & aw_free_q;
    wire w_take   = wvalid & w_free_q;
    wire ar_take  = arvalid & ar_free_q;
    wire wr_ready = ~aw_free_q & ~w_free_q & ~bvalid;

    // Only the low byte lane carries register data; a cleared lane writes nothing.
    assign reg_wr_en   = wr_ready & w_lane_q & sag_writable(aw_idx_q);
    assign reg_wr_idx  = aw_idx_q;
    assign reg_wr_data = w_data_q;
    assign reg_rd_idx  = araddr[ADDR_W-1:2];
    assign awready     = aw_free_q;
    assign wready      = w_free_q;
    assign arready     = ar_free_q;

    // Slots fill on their handshake and empty only when the answer is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_free_q <= 1'b1;
            w_free_q  <= 1'b1;
            ar_free_q <= 1'b1;
            aw_idx_q  <= '0;
            w_data_q  <= '0;
            w_lane_q  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
            rvalid    <= 1'b0;
            rresp     <= RESP_OKAY;
            rdata     <= '0;
        end else begin
            if (aw_take) begin
                aw_idx_q  <= awaddr[ADDR_W-1:2];
                aw_free_q <= 1'b0;
            end
            if (w_take) begin
                w_data_q <= wdata[7:0];
                w_lane_q <= wstrb[0];
                w_free_q <= 1'b0;
            end
            // Unmapped writes answer with an error and change nothing.
            if (wr_ready) begin
                bvalid <= 1'b1;
                bresp  <= sag_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid    <= 1'b0;
                aw_free_q <= 1'b1;
                w_free_q  <= 1'b1;
            end
            // Read data is caught at the address handshake edge.
            if (ar_take) begin
                ar_free_q <= 1'b0;
                rvalid    <= 1'b1;
                rdata     <= {24'h000000, reg_rd_data};
                rresp     <= sag_mapped(reg_rd_idx) ? RESP_OKAY : RESP_SLVERR;
            end
            if (rvalid && rready) begin
                rvalid    <= 1'b0;
                ar_free_q <= 1'b1;
            end
        end
    end

endmodule

/* File: design/sag_ports.sv */
// Two segment-capable ports and one mixed analog port behind an AXI4-Lite slave.
//
// The AXI4-Lite register port was left to the implementer.
module sag_ports
    import sag_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic [7:0]        lcd_segment_drive_a,
    input  wire logic [7:0]        lcd_segment_drive_b,
    input  wire logic [7:0]        pa_pin_in,
    output logic [7:0]             pa_pin_out,
    output logic [7:0]             pa_pin_oe,
    input  wire logic [7:0]        pb_pin_in,
    output logic [7:0]             pb_pin_out,
    output logic [7:0]             pb_pin_oe,
    input  wire logic [7:0]        pm_pin_in,
    output logic [7:0]             pm_pin_out,
    output logic [7:0]             pm_pin_oe,
    output logic [7:0]             mixed_func_level,
    output logic [7:0]             analog_channel_in
);

    // Software-visible state.
    logic [7:0] a_lat_q;   // Segment port A output latch.
    logic [7:0] a_sel_q;   // Segment port A segment select.
    logic [7:0] b_lat_q;   // Segment port B output latch.
    logic [7:0] b_sel_q;   // Segment port B segment select.
    logic [7:0] m_lat_q;   // Mixed port output latch.
    logic [7:0] m_dir_q;   // Mixed port direction, one is output.
    logic       flag_q;    // Analog select flag, one keeps the converter off the pins.

    // Register access strobes from the bus slave.
    logic       reg_wr_en;
    sag_idx_t   reg_wr_idx;
    logic [7:0] reg_wr_data;
    sag_idx_t   reg_rd_idx;
    logic [7:0] reg_rd_data;

    // Pin driver for a segment-capable port: segment drive wins, else an
    // open-drain style latch where a one releases the pin for input use.
    function automatic logic [15:0] seg_pin(input logic [7:0] sel,
                                            input logic [7:0] lcd_segment_drive,
                                            input logic [7:0] lat);
        logic [7:0] o;
        logic [7:0] e;
        o = (sel & lcd_segment_drive) | (~sel & lat);
        e = sel | ~lat;
        return {e, o};
    endfunction

    // Bus slave; all handshake outputs come from its flip-flops.
    sag_axil u_axil (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .awaddr      (awaddr),
        .awvalid     (awvalid),
        .awready     (awready),
        .wdata       (wdata),
        .wstrb       (wstrb),
        .wvalid      (wvalid),
        .wready      (wready),
        .bresp       (bresp),
        .bvalid      (bvalid),
        .bready      (bready),
        .araddr      (araddr),
        .arvalid     (arvalid),
        .arready     (arready),
        .rdata       (rdata),
        .rresp       (rresp),
        .rvalid      (rvalid),
        .rready      (rready),
        .reg_wr_en   (reg_wr_en),
        .reg_wr_idx  (reg_wr_idx),
        .reg_wr_data (reg_wr_data),
        .reg_rd_idx  (reg_rd_idx),
        .reg_rd_data (reg_rd_data)
    );

    // Write decode, one strobe per writable register.
    wire we_a_lat = reg_wr_en & (reg_wr_idx == IDX_A_LAT);
    wire we_a_sel = reg_wr_en & (reg_wr_idx == IDX_A_SEL);
    wire we_b_lat = reg_wr_en & (reg_wr_idx == IDX_B_LAT);
    wire we_b_sel = reg_wr_en & (reg_wr_idx == IDX_B_SEL);
    wire we_m_lat = reg_wr_en & (reg_wr_idx == IDX_M_LAT);
    wire we_m_dir = reg_wr_en & (reg_wr_idx == IDX_M_DIR);
    wire we_conv  = reg_wr_en & (reg_wr_idx == IDX_CONV);

    // Mixed port modes per bit.
    wire [7:0] m_dig_in = ~m_dir_q & m_lat_q;
    wire [7:0] m_zero   = ~m_dir_q & ~m_lat_q;
    wire [7:0] m_analog = m_zero & {8{~flag_q}};

    // Mixed port read: output and digital bits show the pin, analog and
    // forced-zero bits read as zero.
    wire [7:0] m_read = pm_pin_in & (m_dir_q | m_lat_q);

    // Converter control image with the analog select flag in its field.
    wire [7:0] conv_read = 8'({7'h00, flag_q} << FLAG_BIT);

    // Pin driver images for both segment-capable ports.
    wire [15:0] a_drive = seg_pin(a_sel_q, lcd_segment_drive_a, a_lat_q);
    wire [15:0] b_drive = seg_pin(b_sel_q, lcd_segment_drive_b, b_lat_q);

    // Read select; pin addresses sample the live pins in the read cycle.
    assign reg_rd_data = ({8{reg_rd_idx == IDX_A_LAT}} & a_lat_q)
                       | ({8{reg_rd_idx == IDX_A_PIN}} & pa_pin_in)
                       | ({8{reg_rd_idx == IDX_A_SEL}} & a_sel_q)
                       | ({8{reg_rd_idx == IDX_B_LAT}} & b_lat_q)
                       | ({8{reg_rd_idx == IDX_B_PIN}} & pb_pin_in)
                       | ({8{reg_rd_idx == IDX_B_SEL}} & b_sel_q)
                       | ({8{reg_rd_idx == IDX_M_LAT}} & m_read)
                       | ({8{reg_rd_idx == IDX_M_DIR}} & m_dir_q)
                       | ({8{reg_rd_idx == IDX_CONV}}  & conv_read);

    // Segment port A registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            a_lat_q <= RST_ONES;
            a_sel_q <= RST_ZERO;
        end else begin
            if (we_a_lat) begin
                a_lat_q <= reg_wr_data;
            end
            if (we_a_sel) begin
                a_sel_q <= reg_wr_data;
            end
        end
    end

    // Segment port B registers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_lat_q <= RST_ONES;
            b_sel_q <= RST_ZERO;
        end else begin
            if (we_b_lat) begin
                b_lat_q <= reg_wr_data;
            end
            if (we_b_sel) begin
                b_sel_q <= reg_wr_data;
            end
        end
    end

    // Mixed port registers and the analog select flag.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m_lat_q <= RST_ZERO;
            m_dir_q <= RST_ZERO;
            flag_q  <= RST_FLAG;
        end else begin
            if (we_m_lat) begin
                m_lat_q <= reg_wr_data;
            end
            if (we_m_dir) begin
                m_dir_q <= reg_wr_data;
            end
            if (we_conv) begin
                flag_q <= reg_wr_data[FLAG_BIT];
            end
        end
    end

    // Segment pin drivers, registered so the pins never glitch on decode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pa_pin_out <= RST_ONES;
            pa_pin_oe  <= RST_ZERO;
            pb_pin_out <= RST_ONES;
            pb_pin_oe  <= RST_ZERO;
        end else begin
            pa_pin_out <= a_drive[7:0];
            pa_pin_oe  <= a_drive[15:8];
            pb_pin_out <= b_drive[7:0];
            pb_pin_oe  <= b_drive[15:8];
        end
    end

    // Mixed pin drivers and the levels handed to other functions.
    // Bits 1..3 feed counter clock, event counter and interrupt; 4..7 wake-up.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pm_pin_out        <= RST_ZERO;
            pm_pin_oe         <= RST_ZERO;
            mixed_func_level  <= RST_ZERO;
            analog_channel_in <= RST_ZERO;
        end else begin
            pm_pin_out        <= m_lat_q;
            pm_pin_oe         <= m_dir_q;
            mixed_func_level  <= pm_pin_in & m_dig_in;
            analog_channel_in <= m_analog;
        end
    end

    // Checks on the block's own registers and outputs.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // A read request of a given register taken on the bus.
    sequence s_rd(sag_idx_t i);
        arvalid && arready && araddr[ADDR_W-1:2] == i;
    endsequence

    // The first active edge after reset sees every segment register at its reset value.
    property p_rst_seg;
        $rose(aresetn) |-> a_lat_q == RST_ONES && b_lat_q == RST_ONES
            && a_sel_q == RST_ZERO && b_sel_q == RST_ZERO;
    endproperty
    a_rst_seg: assert property (p_rst_seg) else $error("segment reset");

    // The mixed port leaves reset with every pin reading zero.
    property p_rst_mix;
        $rose(aresetn) |-> m_dir_q == RST_ZERO && m_lat_q == RST_ZERO
            && flag_q && mixed_func_level == RST_ZERO;
    endproperty
    a_rst_mix: assert property (p_rst_mix) else $error("mixed reset");

    // Each port A bit on segment drive is driven with the segment signal.
    property p_seg_a;
        a_sel_q != RST_ZERO |=> (pa_pin_oe & $past(a_sel_q)) == $past(a_sel_q)
            && ((pa_pin_out ^ $past(lcd_segment_drive_a)) & $past(a_sel_q)) == RST_ZERO;
    endproperty
    a_seg_a: assert property (p_seg_a) else $error("port A segment drive");

    // Each port B bit on segment drive is driven with the segment signal.
    property p_seg_b;
        b_sel_q != RST_ZERO |=> (pb_pin_oe & $past(b_sel_q)) == $past(b_sel_q)
            && ((pb_pin_out ^ $past(lcd_segment_drive_b)) & $past(b_sel_q)) == RST_ZERO;
    endproperty
    a_seg_b: assert property (p_seg_b) else $error("port B segment drive");

    // Each port A bit in port use shows its latch, a one releasing the pin.
    property p_port_a;
        a_sel_q != RST_ONES |=> ((pa_pin_out ^ $past(a_lat_q)) & ~$past(a_sel_q)) == RST_ZERO
            && ((pa_pin_oe ^ ~$past(a_lat_q)) & ~$past(a_sel_q)) == RST_ZERO;
    endproperty
    a_port_a: assert property (p_port_a) else $error("port A latch drive");

    // With no segment bits, port B shows its latch on every pin.
    property p_port_b;
        b_sel_q == RST_ZERO |=> pb_pin_out == $past(b_lat_q)
            && pb_pin_oe == ~$past(b_lat_q);
    endproperty
    a_port_b: assert property (p_port_b) else $error("port B latch drive");

    // Every output bit of the mixed port drives its latch value.
    property p_mix_out;
        m_dir_q != RST_ZERO |=> pm_pin_oe == $past(m_dir_q)
            && ((pm_pin_out ^ $past(m_lat_q)) & $past(m_dir_q)) == RST_ZERO;
    endproperty
    a_mix_out: assert property (p_mix_out) else $error("mixed output");

    // Every digital input bit hands its pin level to the other functions.
    property p_mix_dig;
        m_dig_in != RST_ZERO |=> (mixed_func_level & $past(m_dig_in))
            == ($past(pm_pin_in) & $past(m_dig_in));
    endproperty
    a_mix_dig: assert property (p_mix_dig) else $error("mixed digital input");

    // With the flag set, bits with both controls clear are held at zero.
    property p_mix_zero;
        flag_q && m_zero != RST_ZERO
            |=> (mixed_func_level & $past(m_zero)) == RST_ZERO && analog_channel_in == RST_ZERO;
    endproperty
    a_mix_zero: assert property (p_mix_zero) else $error("forced zero input");

    // With the flag clear, exactly the bits with both controls clear reach the converter.
    property p_mix_ana;
        !flag_q |=> analog_channel_in == $past(m_zero);
    endproperty
    a_mix_ana: assert property (p_mix_ana) else $error("analog routing");

    // The latch address of port A returns the latch, not the pins.
    property p_rd_lat_a;
        s_rd(IDX_A_LAT) |=> rvalid && rdata[7:0] == $past(a_lat_q);
    endproperty
    a_rd_lat_a: assert property (p_rd_lat_a) else $error("port A latch read");

    // Analog and forced-zero bits of the mixed port read as zero.
    property p_rd_mix;
        s_rd(IDX_M_LAT) |=> rvalid && (rdata[7:0] & $past(m_zero)) == RST_ZERO;
    endproperty
    a_rd_mix: assert property (p_rd_mix) else $error("analog bit reads one");

    // The pin address of port A samples the live pins at the read handshake.
    property p_rd_pin_a;
        s_rd(IDX_A_PIN) |=> rvalid && rdata[7:0] == $past(pa_pin_in);
    endproperty
    a_rd_pin_a: assert property (p_rd_pin_a) else $error("port A pin read");

    // The pin address of port B samples the live pins at the read handshake.
    property p_rd_pin_b;
        s_rd(IDX_B_PIN) |=> rvalid && rdata[7:0] == $past(pb_pin_in) ##1 1;
    endproperty
    a_rd_pin_b: assert property (p_rd_pin_b) else $error("port B pin read");

endmodule

/* File: sim/sag_pin_model.sv */
// Pin-side model: external sources, LCD segment lines and the resolved pin levels.
module sag_pin_model (
    input  wire logic [7:0] ext_a,
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_m,
    input  wire logic [7:0] seg_a,
    input  wire logic [7:0] seg_b,
    input  wire logic [7:0] pa_out,
    input  wire logic [7:0] pa_oe,
    input  wire logic [7:0] pb_out,
    input  wire logic [7:0] pb_oe,
    input  wire logic [7:0] pm_out,
    input  wire logic [7:0] pm_oe,
    output logic      [7:0] pa_in,
    output logic      [7:0] pb_in,
    output logic      [7:0] pm_in,
    output logic      [7:0] lcd_a,
    output logic      [7:0] lcd_b
);
    timeunit 1ns;
    timeprecision 1ps;

    // The LCD driver presents its segment patterns as given by the bench.
    assign lcd_a = seg_a;
    assign lcd_b = seg_b;

    // A driven bit shows the block's value; a released bit shows the external source.
    assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
    assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
    assign pm_in = (pm_oe & pm_out) | (~pm_oe & ext_m);
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the segment and mixed port block over AXI4-Lite.
module tb_top
    import sag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    logic [31:0]       rdata;
    logic [7:0]        lcd_a, lcd_b, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    logic [7:0]        pm_in, pm_out, pm_oe, mfl, aci;
    logic [7:0]        ext_a, ext_b, ext_m, seg_a, seg_b, sg, ex, eo, ev;
    int                n_fail, cmp_count, cyc;

    sag_ports u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .lcd_segment_drive_a(lcd_a), .lcd_segment_drive_b(lcd_b), .pa_pin_in(pa_in),
        .pa_pin_out(pa_out), .pa_pin_oe(pa_oe), .pb_pin_in(pb_in), .pb_pin_out(pb_out),
        .pb_pin_oe(pb_oe), .pm_pin_in(pm_in), .pm_pin_out(pm_out), .pm_pin_oe(pm_oe),
        .mixed_func_level(mfl), .analog_channel_in(aci));

    sag_pin_model u_pins (.ext_a(ext_a), .ext_b(ext_b), .ext_m(ext_m), .seg_a(seg_a),
        .seg_b(seg_b), .pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
        .pm_out(pm_out), .pm_oe(pm_oe), .pa_in(pa_in), .pb_in(pb_in), .pm_in(pm_in),
        .lcd_a(lcd_a), .lcd_b(lcd_b));

    // Free-running 50 ns clock.
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Counts clock cycles from the start of the run.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
    end

    // A hang is cut short well past the expected length of the run.
    initial begin
        wait (cyc == 20000);
        n_fail++;
        end_sim;
    end

    // Compares one value, counting the comparison and any mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One write: address and data offered together, each released when taken.
    task automatic wr(input sag_idx_t i, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic       ta, tw, hb;
        logic [1:0] r;
        @(posedge aclk);
        hb = 1'b0;
        awaddr <= {i, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb) begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            hb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask

    // One read; bits outside the mask m are not compared, upper bits must be zero.
    task automatic rd(input sag_idx_t i, input logic [7:0] m, input logic [7:0] e,
                      input logic [1:0] er);
        logic        ta, hr;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge aclk);
        hr = 1'b0;
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hr) begin
            @(negedge aclk);
            ta = arvalid & arready;
            hr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk(d & {24'hffffff, m}, {24'h0, e & m});
        chk(32'(r), 32'(er));
    endtask

    // Lets the registered pin outputs catch up, then samples mid-cycle.
    task automatic settle;
        @(posedge aclk);
        @(negedge aclk);
    endtask

    initial begin
        aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; awaddr = '0; araddr = '0; wdata = '0;
        wstrb = 4'h0; ext_a = 8'h99; ext_b = 8'h66; ext_m = 8'hff;
        seg_a = 8'h5a; seg_b = 8'ha6; n_fail = 0; cmp_count = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset state of every writable register and of pa_out, pb_out, pm_oe, aci and mfl.
        rd(IDX_A_LAT, 8'hff, RST_ONES, RESP_OKAY);
        rd(IDX_B_LAT, 8'hff, RST_ONES, RESP_OKAY);
        rd(IDX_A_SEL, 8'hff, RST_ZERO, RESP_OKAY);
        rd(IDX_B_SEL, 8'hff, RST_ZERO, RESP_OKAY);
        rd(IDX_M_DIR, 8'hff, RST_ZERO, RESP_OKAY);
        rd(IDX_M_LAT, 8'hff, RST_ZERO, RESP_OKAY);
        rd(IDX_CONV, 8'hff, 8'h01, RESP_OKAY);
        rd(6'h3f, 8'hff, 8'h00, RESP_SLVERR);
        settle;
        chk(32'(pa_out), 32'hff);
        chk(32'(pb_out), 32'hff);
        chk(32'(pm_oe | aci | mfl), 32'h0);
        $display("test reset done, mismatches %0d", n_fail);
        // Segment ports A and B: half the bits on segment drive, half as port bits.
        for (int p = 0; p < 2; p++) begin
            sg = p ? seg_b : seg_a;
            ex = p ? ext_b : ext_a;
            eo = 8'h0f | ~8'h3c;
            ev = (8'h0f & sg) | (~8'h0f & 8'h3c);
            wr(p ? IDX_B_SEL : IDX_A_SEL, 8'h0f, 4'h1, RESP_OKAY);
            wr(p ? IDX_B_LAT : IDX_A_LAT, 8'h3c, 4'h1, RESP_OKAY);
            settle;
            chk(32'(p ? pb_out : pa_out), 32'(ev));
            chk(32'(p ? pb_oe : pa_oe), 32'(eo));
            rd(p ? IDX_B_LAT : IDX_A_LAT, 8'hff, 8'h3c, RESP_OKAY);
            rd(p ? IDX_B_PIN : IDX_A_PIN, 8'hf0, (eo & ev) | (~eo & ex), RESP_OKAY);
            wr(p ? IDX_B_PIN : IDX_A_PIN, 8'h00, 4'h1, RESP_OKAY);
            wr(p ? IDX_B_LAT : IDX_A_LAT, 8'h00, 4'h0, RESP_OKAY);
            rd(p ? IDX_B_LAT : IDX_A_LAT, 8'hff, 8'h3c, RESP_OKAY);
        end
        wr(6'h3f, 8'h12, 4'h1, RESP_SLVERR);
        $display("test segment ports done, mismatches %0d", n_fail);
        // Mixed port: two outputs, digital inputs, then forced-zero or analog bits.
        wr(IDX_M_DIR, 8'h03, 4'h1, RESP_OKAY);
        wr(IDX_M_LAT, 8'h35, 4'h1, RESP_OKAY);
        for (int f = 1; f >= 0; f--) begin
            wr(IDX_CONV, 8'(f), 4'h1, RESP_OKAY);
            settle;
            chk(32'(pm_out), 32'h35);
            chk(32'(pm_oe), 32'h03);
            chk(32'(mfl), 32'h34);
            chk(32'(aci), f ? 32'h0 : 32'hc8);
            rd(IDX_CONV, 8'hff, 8'(f), RESP_OKAY);
            rd(IDX_M_LAT, 8'hff, 8'h35, RESP_OKAY);
        end
        // The pin levels change while the latch stays; reads follow the live pins.
        ext_m <= 8'h0f;
        settle;
        chk(32'(mfl), 32'h04);
        rd(IDX_M_LAT, 8'hff, 8'h05, RESP_OKAY);
        $display("test mixed port done, mismatches %0d", n_fail);
        end_sim;
    end
endmodule
